// file: design/asram_pkg.sv
// Behaviour
// RL1: Chip select low selects the memory; sixteen address bits pick one single-bit cell.
// RL2: Chip select high deselects the memory; its output floats and power drops.
// RL3: A read keeps write strobe high all cycle with chip select low.
// RL4: Read latency counts from the later of chip select fall or address valid.
// RL5: Address change under chip select starts a new read after address access time.
// RL6: Chip select falling with stable address gives data after chip-select access time.
// RL7: Chip-select access time does not depend on the preceding deselect interval.
// RL8: A write runs while both chip select and write strobe are low.
// RL9: With strobe falling last, output turns on then releases within write-disable delay.
// RL10: Drive write data only after the write-to-output-disable interval has passed.
// RL11: Write ended by strobe rising needs data setup and hold about that edge.
// RL12: Strobe rising with chip select low makes the output drive again.
// RL13: Write ended by chip select rising references setup and hold to it; output floats.
// RL14: Strobe low when chip select falls keeps the output floating all cycle.
// RL15: Address stays stable while chip select and strobe are both low.
package asram_pkg;
    localparam int ASRAM_AW = 16;
    localparam int ASRAM_CLK_PS = 40000;
    // Timing figures in ns, slowest speed grade
    localparam int ASRAM_T_ACCESS_NS = 55;
    localparam int ASRAM_T_AS_NS = 5;
    localparam int ASRAM_T_WP_NS = 25;
    localparam int ASRAM_T_WZ_NS = 25;
    localparam int ASRAM_T_DW_NS = 20;
    localparam int ASRAM_T_WR_NS = 5;
    localparam int ASRAM_T_HZ_NS = 30;
    // Least times round up to whole cycles, never below one
    function automatic int asram_cyc(input int ns);
        int c;
        c = (ns * 1000 + ASRAM_CLK_PS - 1) / ASRAM_CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction : asram_cyc
    localparam int ASRAM_C_ACCESS = asram_cyc(ASRAM_T_ACCESS_NS);
    localparam int ASRAM_C_AS = asram_cyc(ASRAM_T_AS_NS);
    localparam int ASRAM_C_WZ = asram_cyc(ASRAM_T_WZ_NS);
    localparam int ASRAM_C_DW = asram_cyc(ASRAM_T_DW_NS);
    localparam int ASRAM_C_WP = (asram_cyc(ASRAM_T_WP_NS) > ASRAM_C_WZ + ASRAM_C_DW) ?
        asram_cyc(ASRAM_T_WP_NS) : ASRAM_C_WZ + ASRAM_C_DW;
    localparam int ASRAM_C_WR = asram_cyc(ASRAM_T_WR_NS);
    localparam int ASRAM_C_HZ = asram_cyc(ASRAM_T_HZ_NS);
    localparam int ASRAM_CW = 4;

    typedef enum logic [2:0] {
        ASRAM_IDLE, ASRAM_RSEL, ASRAM_RWAIT, ASRAM_WSET, ASRAM_WLOW, ASRAM_WEND, ASRAM_GAP
    } asram_state_t;

    typedef struct packed {
        logic [ASRAM_AW-1:0] cell_address;
        logic sel_n;
        logic wr_n;
        logic din;
        logic din_oe;
    } asram_pins_t;

    typedef struct packed {
        asram_state_t st;
        logic [ASRAM_CW-1:0] cnt;
        asram_pins_t pins;
        logic rdata;
        logic rvalid;
        logic wdone;
        logic q_m;
        logic q_s;
    } asram_regs_t;
endpackage : asram_pkg

// file: design/asram_host.sv
`timescale 1ns/100ps
module asram_host
    import asram_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [ASRAM_AW-1:0] req_addr_i,
    input wire logic req_wdata_i,
    output logic req_ready_o,
    output logic rd_valid_o,
    output logic rd_data_o,
    output logic wr_done_o,
    output logic [ASRAM_AW-1:0] cell_address_o,
    output logic sel_n_o,
    output logic wr_n_o,
    output logic din_o,
    output logic din_oe_o,
    input wire logic q_i
);
    asram_regs_t r_q;
    asram_regs_t r_d;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Wait loaded on entry to each step
    function automatic logic [ASRAM_CW-1:0] asram_hold(input asram_state_t st);
        logic [ASRAM_CW-1:0] n;
        n = '0;
        unique case (st)
            ASRAM_IDLE: begin
                n = '0;
            end
            ASRAM_RSEL: begin
                n = '0;
            end
            ASRAM_RWAIT: begin
                n = ASRAM_CW'(ASRAM_C_ACCESS + 2);
            end
            ASRAM_WSET: begin
                n = ASRAM_CW'(ASRAM_C_AS);
            end
            ASRAM_WLOW: begin
                n = ASRAM_CW'(ASRAM_C_WP);
            end
            ASRAM_WEND: begin
                n = ASRAM_CW'(ASRAM_C_WR);
            end
            ASRAM_GAP: begin
                n = ASRAM_CW'(ASRAM_C_HZ);
            end
            default: begin
                n = '0;
            end
        endcase
        return n;
    endfunction : asram_hold

    // Wait counter has run out
    function automatic logic asram_expired(input logic [ASRAM_CW-1:0] c);
        return (c == '0);
    endfunction : asram_expired

    // Ready while the sequencer is idle
    function automatic logic asram_is_ready(input asram_state_t st);
        return (st == ASRAM_IDLE);
    endfunction : asram_is_ready

    // Request address and data onto the pins, strobes untouched
    function automatic asram_pins_t asram_capture(input asram_pins_t p, input logic [ASRAM_AW-1:0] a,
        input logic d);
        asram_pins_t r;
        r = p;
        r.cell_address = a;
        r.din = d;
        return r;
    endfunction : asram_capture

    // Chip select drops; the strobe drops with it only for a write
    function automatic asram_pins_t asram_select(input asram_pins_t p, input logic wr);
        asram_pins_t r;
        r = p;
        r.sel_n = 1'b0;
        r.wr_n = !wr;
        return r;
    endfunction : asram_select

    // Both strobes released, address and data kept
    function automatic asram_pins_t asram_release(input asram_pins_t p);
        asram_pins_t r;
        r = p;
        r.sel_n = 1'b1;
        r.wr_n = 1'b1;
        return r;
    endfunction : asram_release

    // Write data driver onto the shared data line, or off it
    function automatic asram_pins_t asram_data_drive(input asram_pins_t p, input logic en);
        asram_pins_t r;
        r = p;
        r.din_oe = en;
        return r;
    endfunction : asram_data_drive

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        r_d = r_q;
        // ----------------------------------------
        // Synchroniser and pulses
        // ----------------------------------------
        r_d.q_m = q_i;
        r_d.q_s = r_q.q_m;
        r_d.rvalid = 1'b0;
        r_d.wdone = 1'b0;
        // ----------------------------------------
        // Wait counter
        // ----------------------------------------
        if (!asram_expired(r_q.cnt)) begin
            r_d.cnt = r_q.cnt - 1'b1;
        end
        // ----------------------------------------
        // Steps
        // ----------------------------------------
        unique case (r_q.st)
            ASRAM_IDLE: begin
                if (req_valid_i) begin
                    r_d.pins = asram_capture(r_q.pins, req_addr_i, req_wdata_i); // RL1 RL15
                    if (req_write_i) begin
                        r_d.st = ASRAM_WSET;
                        r_d.cnt = asram_hold(ASRAM_WSET);
                    end else begin
                        r_d.pins = asram_select(r_d.pins, 1'b0); // RL3 RL6
                        r_d.st = ASRAM_RWAIT;
                        r_d.cnt = asram_hold(ASRAM_RWAIT); // RL4 RL7
                    end
                end
            end
            ASRAM_RWAIT: begin
                if (asram_expired(r_q.cnt)) begin
                    r_d.rdata = r_q.q_s; // RL5
                    r_d.rvalid = 1'b1;
                    r_d.pins = asram_release(r_q.pins); // RL2
                    r_d.st = ASRAM_GAP;
                    r_d.cnt = asram_hold(ASRAM_GAP);
                end
            end
            ASRAM_WSET: begin
                if (asram_expired(r_q.cnt)) begin
                    r_d.pins = asram_select(r_q.pins, 1'b1); // RL8 RL14
                    r_d.st = ASRAM_WLOW;
                    r_d.cnt = asram_hold(ASRAM_WLOW);
                end
            end
            ASRAM_WLOW: begin
                if (r_q.cnt == ASRAM_CW'(ASRAM_C_DW)) begin
                    r_d.pins = asram_data_drive(r_d.pins, 1'b1); // RL10
                end
                if (asram_expired(r_q.cnt)) begin
                    r_d.pins = asram_release(r_d.pins); // RL11 RL13
                    r_d.st = ASRAM_WEND;
                    r_d.cnt = asram_hold(ASRAM_WEND);
                end
            end
            ASRAM_WEND: begin
                if (asram_expired(r_q.cnt)) begin
                    r_d.pins = asram_data_drive(r_d.pins, 1'b0);
                    r_d.wdone = 1'b1;
                    r_d.st = ASRAM_GAP;
                    r_d.cnt = asram_hold(ASRAM_GAP);
                end
            end
            ASRAM_GAP: begin
                if (asram_expired(r_q.cnt)) begin
                    r_d.st = ASRAM_IDLE;
                end
            end
            default: begin
                r_d.st = ASRAM_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_q <= '{
                st: ASRAM_IDLE,
                cnt: '0,
                pins: '{
                    cell_address: '0,
                    sel_n: 1'b1,
                    wr_n: 1'b1,
                    din: 1'b0,
                    din_oe: 1'b0
                },
                rdata: 1'b0,
                rvalid: 1'b0,
                wdone: 1'b0,
                q_m: 1'b0,
                q_s: 1'b0
            };
        end else begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------
    // Host side
    // ----------------------------------------
    assign req_ready_o = asram_is_ready(r_q.st);
    assign rd_valid_o = r_q.rvalid;
    assign rd_data_o = r_q.rdata;
    assign wr_done_o = r_q.wdone;

    // ----------------------------------------
    // Memory pins
    // ----------------------------------------
    assign cell_address_o = r_q.pins.cell_address;
    assign sel_n_o = r_q.pins.sel_n;
    assign wr_n_o = r_q.pins.wr_n;
    assign din_o = r_q.pins.din;
    assign din_oe_o = r_q.pins.din_oe;
endmodule : asram_host

// file: bench/asram_host_properties.sv
`timescale 1ns/100ps
module asram_host_properties
    import asram_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [ASRAM_AW-1:0] cell_address_o,
    input wire logic sel_n_o,
    input wire logic wr_n_o,
    input wire logic din_o,
    input wire logic din_oe_o
);
    // ----------
    // Pin order
    // ----------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    property p_rd; $fell(sel_n_o) && wr_n_o |-> (wr_n_o && !sel_n_o) [*5] ##1 sel_n_o; endproperty
    a_rd: assert property (p_rd) else $error("strobe moved in read");
    property p_wz; $rose(din_oe_o) |-> !wr_n_o && !$past(wr_n_o, 2); endproperty
    a_wz: assert property (p_wz) else $error("data driven early");
    property p_dh; $rose(wr_n_o) |-> din_oe_o && $stable(din_o) && $past(din_oe_o); endproperty
    a_dh: assert property (p_dh) else $error("write data not held");
    property p_end; $rose(sel_n_o) && !$past(wr_n_o) |-> wr_n_o ##2 !din_oe_o; endproperty
    a_end: assert property (p_end) else $error("write end wrong");
    property p_adr; !sel_n_o && !wr_n_o |-> $stable(cell_address_o); endproperty
    a_adr: assert property (p_adr) else $error("address moved in write");
endmodule : asram_host_properties
bind asram_host asram_host_properties asram_host_properties_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .cell_address_o(cell_address_o), .sel_n_o(sel_n_o), .wr_n_o(wr_n_o), .din_o(din_o), .din_oe_o(din_oe_o));

// file: bench/asram_mem_model.sv
`timescale 1ns/100ps
module asram_mem_model
    import asram_pkg::*;
(
    input wire logic [ASRAM_AW-1:0] cell_address_i,
    input wire logic sel_n_i,
    input wire logic wr_n_i,
    input wire logic din_i,
    output logic q_o
);
    // ----------
    // Cell array
    // ----------
    logic cells [0:65535];
    logic on_q = 1'b0;
    wire [ASRAM_AW:0] settled;
    assign #(ASRAM_T_ACCESS_NS) settled = {cell_address_i, sel_n_i};
    always @(negedge sel_n_i) on_q = wr_n_i;
    always @(posedge sel_n_i) on_q = 1'b0;
    always @(negedge wr_n_i) on_q = 1'b0;
    always @(posedge wr_n_i) on_q = !sel_n_i;
    always @(sel_n_i or wr_n_i or din_i or cell_address_i) if (!sel_n_i && !wr_n_i) cells[cell_address_i] = din_i;
    assign q_o = (on_q && settled === {cell_address_i, sel_n_i}) ? cells[cell_address_i] : ~cells[cell_address_i];
endmodule : asram_mem_model

// file: bench/test_async_sram_64kx1_access.sv
`timescale 1ns/100ps
module test_async_sram_64kx1_access
    import asram_pkg::*;
;
    logic mclk_i = 1'b0, nrst_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0, req_wdata_i = 1'b0;
    logic [ASRAM_AW-1:0] req_addr_i = 16'h0000, cell_address_o;
    logic req_ready_o, rd_valid_o, rd_data_o, wr_done_o, sel_n_o, wr_n_o, din_o, din_oe_o, q_i;
    int fails = 0, comparisons = 0, cycles = 0;
    asram_host asram_host_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .wr_done_o(wr_done_o), .cell_address_o(cell_address_o),
        .sel_n_o(sel_n_o), .wr_n_o(wr_n_o), .din_o(din_o), .din_oe_o(din_oe_o), .q_i(q_i));
    asram_mem_model asram_mem_model_inst (.cell_address_i(cell_address_o), .sel_n_i(sel_n_o), .wr_n_i(wr_n_o),
        .din_i(din_o), .q_o(q_i));
    // ----------
    // Tasks
    // ----------
    task automatic check(input string what, input logic seen, input logic exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up();
        if (fails == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic access(input logic w, input logic [ASRAM_AW-1:0] a, input logic d);
        req_valid_i = 1'b1;
        req_write_i = w;
        req_addr_i = a;
        req_wdata_i = d;
        while (req_ready_o !== 1'b1) @(posedge mclk_i) #1;
        @(posedge mclk_i) #1;
        req_valid_i = 1'b0;
        check("req_ready", req_ready_o, 1'b0);
        while (rd_valid_o !== 1'b1 && wr_done_o !== 1'b1) @(posedge mclk_i) #1;
        check(w ? "wr_done" : "rd_valid", w ? wr_done_o : rd_valid_o, 1'b1);
        check("cell_address", cell_address_o === a, 1'b1);
        check("sel_n", sel_n_o, 1'b1);
        check("wr_n", wr_n_o, 1'b1);
        check("din_oe", din_oe_o, 1'b0);
        @(posedge mclk_i) #1;
        check("pulse", rd_valid_o | wr_done_o, 1'b0);
    endtask : access
    task automatic sc_reset();
        check("sel_n", sel_n_o, 1'b1);
        check("din_oe", din_oe_o, 1'b0);
        check("wr_n", wr_n_o, 1'b1);
        check("req_ready", req_ready_o, 1'b1);
    endtask : sc_reset
    task automatic sc_write_read();
        logic [ASRAM_AW-1:0] addrs [4] = '{16'h0000, 16'hffff, 16'h5a5a, 16'ha5a5};
        for (int i = 0; i < 4; i++) access(1'b1, addrs[i], i[0]);
        access(1'b1, 16'h0000, 1'b1);
        access(1'b1, 16'h0000, 1'b0);
        for (int i = 0; i < 4; i++) begin
            access(1'b0, addrs[i], 1'b0);
            check("rd_data", rd_data_o, i[0]);
        end
    endtask : sc_write_read
    initial forever #20 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 1000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        #1 sc_reset();
        nrst_i = 1'b1;
        @(posedge mclk_i) #1;
        sc_write_read();
        wrap_up();
    end
endmodule : test_async_sram_64kx1_access
